// *** led_fault_ctrl.sv ***
// Contract
// R1 - Open/short during a high dim pulse pulls fault low and updates status.
// R2 - Fault state sets and clears on its own, only while pulse is high.
// R3 - With the pulse low, the fault state holds.
// R4 - Sink current rises when lowest channel is below reference; code falls only when above reference, holds when equal.
// R5 - Sink current is an 8-bit code, 0.78 uA a step, 200 uA full.
// R6 - Code updates once per frame, when the first line gate turns on.
// R7 - Boot soft start, duration from 3-bit field at address 0x000.
// R8 - Reference select: 0..3 give four levels, 4 to 7 the highest.
// R9 - Short threshold from 2-bit field, or the pin when external flag set.
// R10 - Supply over-voltage threshold chosen by a 2-bit field.
// R11 - Frame sync stays between 50 Hz and the line-count maximum.
// R12 - Each frame sync pulse lasts at least 50 us.
// R13 - Dim pulses are programmed no shorter than 0.6 us.
// R14 - Every one of 24 channels has its own dim pulse.
// R15 - Line gates turn on in order, first to eighth, each frame.
// R16 - Code steps by one per update, saturating at both ends.
module led_fault_ctrl
	import led_fault_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [8:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic [23:0] channel_dim_pulse,
	input wire logic [23:0] open_detect,
	input wire logic [23:0] short_detect,
	input wire logic [7:0] line_gate,
	input wire logic fb_below_ref,
	input wire logic fb_above_ref,
	output logic fault_out_n,
	output logic [7:0] fb_sink_code,
	output logic [2:0] fb_ref_select,
	output logic [1:0] short_thr_select,
	output logic short_thr_external,
	output logic [1:0] switch_supply_ovp_select,
	output logic [15:0] error_mask_ctrl,
	output logic [15:0] precharge_enable_ctrl,
	output logic soft_start_active
);
	// ==========================================================
	// Register storage
	logic [15:0] soft_start_ctrl;
	logic [15:0] short_threshold_ctrl;
	logic [15:0] fb_ref_ctrl;
	logic [23:0] open_flag;
	logic [23:0] short_flag;
	logic gate1_d;
	logic [7:0] ss_count;
	logic [7:0] ss_target;
	logic ss_running;

	// Per-channel open and short flags, gated by each dim pulse
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			status_bit u_open (
				.clk_sys(clk_sys),
				.rst(rst),
				.dim_pulse(channel_dim_pulse[gi]), // [R14]
				.detect(open_detect[gi]),
				.flag(open_flag[gi])
			);
			status_bit u_short (
				.clk_sys(clk_sys),
				.rst(rst),
				.dim_pulse(channel_dim_pulse[gi]),
				.detect(short_detect[gi]),
				.flag(short_flag[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Decode
	wire wr_ss = reg_wr && (reg_addr == ADDR_SOFT_START);
	wire wr_mask = reg_wr && (reg_addr == ADDR_ERROR_MASK);
	wire wr_prc = reg_wr && (reg_addr == ADDR_PRECHARGE);
	wire wr_sh = reg_wr && (reg_addr == ADDR_SHORT_THR);
	wire wr_ref = reg_wr && (reg_addr == ADDR_FB_REF);
	wire [2:0] soft_start_time = soft_start_ctrl[SS_TIME_LSB +: 3];
	// Masked channels never reach the fault pin
	wire [23:0] unmask = ~{8'h00, error_mask_ctrl};
	wire any_fault = |((open_flag | short_flag) & unmask); // [R1]
	// First gate rising marks the frame update instant
	wire frame_tick = line_gate[0] && !gate1_d; // [R6] [R15]
	// Count stops one short of the target so a step lands every 2^n
	// frames; a smaller time written mid soft start cannot overshoot
	wire [7:0] ss_last = ss_target - SS_ONE;
	wire ss_hold = ss_running && (ss_count < ss_last); // [R7]
	wire code_up = fb_below_ref && (fb_sink_code != CODE_FULL); // [R5]
	wire code_dn = fb_above_ref && !fb_below_ref &&
		(fb_sink_code != CODE_ZERO);
	wire [7:0] next_ss_target = SS_ONE << soft_start_time; // [R7]

	// Read mux; unmapped addresses read zero
	logic [15:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			ADDR_SOFT_START: rd_mux = soft_start_ctrl;
			ADDR_ERROR_MASK: rd_mux = error_mask_ctrl;
			ADDR_PRECHARGE: rd_mux = precharge_enable_ctrl;
			ADDR_SHORT_THR: rd_mux = short_threshold_ctrl;
			ADDR_FB_REF: rd_mux = fb_ref_ctrl;
			ADDR_OPEN_STAT_LO: rd_mux = open_flag[15:0];
			ADDR_OPEN_STAT_HI: rd_mux = {8'h00, open_flag[23:16]};
			ADDR_SHORT_STAT_LO: rd_mux = short_flag[15:0];
			ADDR_SHORT_STAT_HI: rd_mux = {8'h00, short_flag[23:16]};
			ADDR_FB_CODE: rd_mux = {8'h00, fb_sink_code};
			default: rd_mux = 16'h0000;
		endcase
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			soft_start_ctrl <= SOFT_START_RST;
			error_mask_ctrl <= CTRL_RST;
			precharge_enable_ctrl <= CTRL_RST;
			short_threshold_ctrl <= CTRL_RST;
			fb_ref_ctrl <= CTRL_RST;
			reg_rdata <= 16'h0000;
		end else begin
			if (wr_ss) soft_start_ctrl <= reg_wdata;
			if (wr_mask) error_mask_ctrl <= reg_wdata;
			if (wr_prc) precharge_enable_ctrl <= reg_wdata;
			if (wr_sh) short_threshold_ctrl <= reg_wdata;
			if (wr_ref) fb_ref_ctrl <= reg_wdata;
			if (reg_rd) reg_rdata <= rd_mux;
		end
	end

	// Threshold, reference and over-voltage selects and the fault pin, registered for clean outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fb_ref_select <= 3'h0;
			short_thr_select <= 2'h0;
			short_thr_external <= 1'b0;
			switch_supply_ovp_select <= 2'h0;
			fault_out_n <= 1'b1;
		end else begin
			fb_ref_select <= fb_ref_ctrl[REF_SEL_LSB +: 3]; // [R8]
			short_thr_select <= short_threshold_ctrl[THR_SEL_LSB +: 2]; // [R9]
			short_thr_external <= short_threshold_ctrl[THR_EXT_BIT]; // [R9]
			switch_supply_ovp_select <=
				short_threshold_ctrl[OVP_LSB +: 2]; // [R10]
			fault_out_n <= !any_fault; // [R1]
		end
	end

	// ==========================================================
	// Feedback code: one step per frame, slowed during soft start
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			gate1_d <= 1'b0;
			fb_sink_code <= CODE_ZERO;
			ss_running <= 1'b1;
			ss_count <= 8'h00;
			ss_target <= SS_ONE;
			soft_start_active <= 1'b1;
		end else begin
			gate1_d <= line_gate[0];
			ss_target <= next_ss_target;
			soft_start_active <= ss_running;
			if (frame_tick) begin
				if (ss_hold) begin
					ss_count <= ss_count + 8'h01; // [R7]
				end else begin
					ss_count <= 8'h00;
					if (code_up) begin
						fb_sink_code <= fb_sink_code + CODE_STEP; // [R4] [R16]
					end else if (code_dn) begin
						fb_sink_code <= fb_sink_code - CODE_STEP; // [R4] [R16]
					end
					// Soft start ends once the code first needs no raise
					if (ss_running && !fb_below_ref) ss_running <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Checks
	// Channel 20 watches the short path, in the upper status word
	localparam int WATCH_CH = 20;

	// Open on channel 0 pulls the pin low two edges later
	fault_follows_a: assert property ( // [R1]
		@(posedge clk_sys) disable iff (rst)
		(channel_dim_pulse[0] && open_detect[0] && !error_mask_ctrl[0])
		|=> ##1 !fault_out_n)
		else $error("fault pin not low after open on channel 0");
	// Any unmasked flag drives the pin low, none lets it go high
	fault_set_a: assert property ( // [R1]
		@(posedge clk_sys) disable iff (rst)
		any_fault |=> !fault_out_n)
		else $error("fault pin high with an unmasked flag");
	fault_clear_a: assert property ( // [R2]
		@(posedge clk_sys) disable iff (rst)
		!any_fault |=> fault_out_n)
		else $error("fault pin low with no unmasked flag");

	// Flags hold with the pulse low and follow the detector when high
	flag_holds_a: assert property ( // [R3]
		@(posedge clk_sys) disable iff (rst)
		!channel_dim_pulse[0] |=> $stable(open_flag[0]))
		else $error("channel 0 flag changed with pulse low");
	flag_clears_a: assert property ( // [R2]
		@(posedge clk_sys) disable iff (rst)
		(channel_dim_pulse[0] && !open_detect[0]) |=> !open_flag[0])
		else $error("channel 0 flag not cleared during pulse");
	short_sets_a: assert property ( // [R1]
		@(posedge clk_sys) disable iff (rst)
		(channel_dim_pulse[WATCH_CH] && short_detect[WATCH_CH])
		|=> short_flag[WATCH_CH])
		else $error("short flag not set during pulse");
	short_holds_a: assert property ( // [R3]
		@(posedge clk_sys) disable iff (rst)
		!channel_dim_pulse[WATCH_CH] |=> $stable(short_flag[WATCH_CH]))
		else $error("short flag changed with pulse low");
	short_clears_a: assert property ( // [R2]
		@(posedge clk_sys) disable iff (rst)
		(channel_dim_pulse[WATCH_CH] && !short_detect[WATCH_CH])
		|=> !short_flag[WATCH_CH])
		else $error("short flag not cleared during pulse");

	// Code moves only at the frame instant, one step at a time
	code_frame_a: assert property ( // [R6]
		@(posedge clk_sys) disable iff (rst)
		!frame_tick |=> $stable(fb_sink_code))
		else $error("code moved outside frame instant");
	code_step_a: assert property ( // [R4]
		@(posedge clk_sys) disable iff (rst)
		(frame_tick && !ss_hold && fb_below_ref &&
		fb_sink_code != CODE_FULL)
		|=> fb_sink_code == $past(fb_sink_code) + CODE_STEP)
		else $error("code did not step up");
	code_down_a: assert property ( // [R4]
		@(posedge clk_sys) disable iff (rst)
		(frame_tick && !ss_hold && fb_above_ref && !fb_below_ref &&
		fb_sink_code != CODE_ZERO)
		|=> fb_sink_code == $past(fb_sink_code) - CODE_STEP)
		else $error("code did not step down");
	code_sat_a: assert property ( // [R16]
		@(posedge clk_sys) disable iff (rst)
		(fb_sink_code == CODE_FULL && !fb_above_ref)
		|=> fb_sink_code == CODE_FULL)
		else $error("code wrapped past full scale");
	code_floor_a: assert property ( // [R16]
		@(posedge clk_sys) disable iff (rst)
		(fb_sink_code == CODE_ZERO && !fb_below_ref)
		|=> fb_sink_code == CODE_ZERO)
		else $error("code wrapped below zero");

	// Soft start skips steps, ends at the first unskipped frame with no raise
	ss_divide_a: assert property ( // [R7]
		@(posedge clk_sys) disable iff (rst)
		(frame_tick && ss_hold) |=> $stable(fb_sink_code))
		else $error("code stepped on a skipped soft start frame");
	ss_end_a: assert property ( // [R7]
		@(posedge clk_sys) disable iff (rst)
		(frame_tick && !ss_hold && !fb_below_ref) |=> !ss_running)
		else $error("soft start did not end");
	ss_once_a: assert property ( // [R7]
		@(posedge clk_sys) disable iff (rst)
		!ss_running |=> !ss_running)
		else $error("soft start restarted outside reset");
	ssa_follow_a: assert property ( // [R7]
		@(posedge clk_sys) disable iff (rst)
		soft_start_active == $past(ss_running))
		else $error("soft start flag out of step");

	// Selects reach their outputs two edges after the write
	ref_sel_a: assert property ( // [R8]
		@(posedge clk_sys) disable iff (rst)
		wr_ref |=> ##1 fb_ref_select == $past(reg_wdata[2:0], 2))
		else $error("reference select not applied");
	thr_sel_a: assert property ( // [R9]
		@(posedge clk_sys) disable iff (rst)
		wr_sh |=> ##1 short_thr_select ==
		$past(reg_wdata[THR_SEL_LSB +: 2], 2))
		else $error("short threshold select not applied");
	thr_ext_a: assert property ( // [R9]
		@(posedge clk_sys) disable iff (rst)
		wr_sh |=> ##1 short_thr_external == $past(reg_wdata[2], 2))
		else $error("external threshold flag not applied");
	ovp_sel_a: assert property ( // [R10]
		@(posedge clk_sys) disable iff (rst)
		wr_sh |=> ##1 switch_supply_ovp_select ==
		$past(reg_wdata[OVP_LSB +: 2], 2))
		else $error("over-voltage select not applied");
endmodule // led_fault_ctrl

// *** led_fault_pkg.sv ***
package led_fault_pkg;
	// ==========================================================
	// Sizes
	localparam int NUM_CH = 24;
	localparam int NUM_LINES = 8;
	localparam int CODE_W = 8;
	localparam int REG_W = 16;
	localparam int ADDR_W = 9;

	// ==========================================================
	// Register addresses
	localparam logic [8:0] ADDR_SOFT_START = 9'h000;
	localparam logic [8:0] ADDR_ERROR_MASK = 9'h003;
	localparam logic [8:0] ADDR_PRECHARGE = 9'h005;
	localparam logic [8:0] ADDR_SHORT_THR = 9'h006;
	localparam logic [8:0] ADDR_FB_REF = 9'h007;
	localparam logic [8:0] ADDR_OPEN_STAT_LO = 9'h010;
	localparam logic [8:0] ADDR_OPEN_STAT_HI = 9'h011;
	localparam logic [8:0] ADDR_SHORT_STAT_LO = 9'h012;
	localparam logic [8:0] ADDR_SHORT_STAT_HI = 9'h013;
	localparam logic [8:0] ADDR_FB_CODE = 9'h014;

	// ==========================================================
	// Field positions and reset values
	localparam int SS_TIME_LSB = 0;
	localparam int REF_SEL_LSB = 0;
	localparam int THR_SEL_LSB = 0;
	localparam int THR_EXT_BIT = 2;
	localparam int OVP_LSB = 4;
	localparam logic [15:0] SOFT_START_RST = 16'h0000;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [7:0] CODE_ZERO = 8'h00;
	localparam logic [7:0] CODE_FULL = 8'hFF;
	localparam logic [7:0] CODE_STEP = 8'h01;
	// Soft start: frames per code step = 1 << soft_start_time
	localparam logic [7:0] SS_ONE = 8'h01;
endpackage

// *** status_bit.sv ***
module status_bit
	import led_fault_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic dim_pulse,
	input wire logic detect,
	output logic flag
);
	// ==========================================================
	// Flag follows detector only while the pulse is high
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flag <= 1'b0;
		end else if (dim_pulse) begin // [R2]
			flag <= detect;
		end // [R3]
	end
endmodule // status_bit

// *** fb_network.sv ***
module fb_network (
	input wire logic [7:0] fb_sink_code,
	input wire logic [8:0] target,
	output logic fb_below_ref,
	output logic fb_above_ref
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Lowest channel voltage follows the sink code with no lag
	// A target above 0xFF keeps the loop pushing up, for saturation
	assign fb_below_ref = {1'b0, fb_sink_code} < target;
	assign fb_above_ref = {1'b0, fb_sink_code} > target;
endmodule // fb_network

// *** testbench.sv ***
module testbench
	import led_fault_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [8:0] reg_addr = 9'h000, target = 9'h000;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic [15:0] mask_q, prc_q;
	logic [23:0] dim = 24'h00_0000, opn = 24'h00_0000, sht = 24'h00_0000;
	logic [7:0] line_gate = 8'h00, code;
	logic below, above, fault_out_n, ssa, ext;
	logic [2:0] refsel;
	logic [1:0] thr, ovp;
	int n_fail = 0, comparisons = 0;
	// ==========================================================
	// Clock, block under test and far side
	initial forever #20 clk_sys = ~clk_sys;
	led_fault_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .channel_dim_pulse(dim), .open_detect(opn),
		.short_detect(sht), .line_gate(line_gate), .fb_below_ref(below),
		.fb_above_ref(above), .fault_out_n(fault_out_n), .fb_sink_code(code),
		.fb_ref_select(refsel), .short_thr_select(thr),
		.short_thr_external(ext), .switch_supply_ovp_select(ovp),
		.error_mask_ctrl(mask_q), .precharge_enable_ctrl(prc_q),
		.soft_start_active(ssa));
	fb_network far_side (.fb_sink_code(code), .target(target),
		.fb_below_ref(below), .fb_above_ref(above));
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Read data is registered, so it is looked at one edge after the strobe
	task automatic rd(input logic [8:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		#1 chk(reg_rdata, e);
	endtask
	// One frame walks the line gates first to eighth, a cycle each
	// The block counts gate edges, not time, so frames are compressed
	// far below the rate and sync-width limits kept on real pins
	task automatic frames(input int n);
		repeat (n) for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			line_gate <= 8'h01 << i;
		end
		@(posedge clk_sys);
		line_gate <= 8'h00;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================================
	// Watchdog, far beyond the few thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		report_and_stop;
	end
	// ==========================================================
	// Tests
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		#1 chk({15'h0000, fault_out_n}, 16'h0001);
		chk({15'h0000, ssa}, 16'h0001);
		chk({8'h00, code}, 16'h0000);
		// Registers: reset values, read-only status, unmapped place
		rd(ADDR_SOFT_START, 16'h0000);
		rd(ADDR_ERROR_MASK, 16'h0000);
		rd(ADDR_SHORT_THR, 16'h0000);
		wr(ADDR_PRECHARGE, 16'h5A3C);
		rd(ADDR_PRECHARGE, 16'h5A3C);
		chk(prc_q, 16'h5A3C);
		wr(ADDR_OPEN_STAT_LO, 16'hFFFF);
		rd(ADDR_OPEN_STAT_LO, 16'h0000);
		rd(9'h100, 16'h0000);
		for (int v = 0; v < 8; v++) begin
			wr(ADDR_FB_REF, 16'(v));
			repeat (2) @(posedge clk_sys);
			#1 chk({13'h0000, refsel}, 16'(v));
		end
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_SHORT_THR, 16'(k * 16 + (k % 2) * 4 + k));
			repeat (2) @(posedge clk_sys);
			#1 chk({11'h000, ovp, ext, thr}, 16'(k * 8 + (k % 2) * 4 + k));
		end
		$display("test registers done");
		// Fault path: set, hold while pulse low, clear, high channel, mask
		// Every pulse phase lasts at least 16 cycles, over 0.6 us
		@(posedge clk_sys);
		dim[0] <= 1'b1;
		opn[0] <= 1'b1;
		repeat (16) @(posedge clk_sys);
		#1 chk({15'h0000, fault_out_n}, 16'h0000);
		rd(ADDR_OPEN_STAT_LO, 16'h0001);
		@(posedge clk_sys);
		dim[0] <= 1'b0;
		opn[0] <= 1'b0;
		repeat (16) @(posedge clk_sys);
		#1 chk({15'h0000, fault_out_n}, 16'h0000);
		rd(ADDR_OPEN_STAT_LO, 16'h0001);
		@(posedge clk_sys);
		dim[0] <= 1'b1;
		repeat (16) @(posedge clk_sys);
		#1 chk({15'h0000, fault_out_n}, 16'h0001);
		rd(ADDR_OPEN_STAT_LO, 16'h0000);
		@(posedge clk_sys);
		dim[20] <= 1'b1;
		sht[20] <= 1'b1;
		repeat (16) @(posedge clk_sys);
		#1 chk({15'h0000, fault_out_n}, 16'h0000);
		rd(ADDR_SHORT_STAT_HI, 16'h0010);
		// Masked channel 0 flags its status but leaves the pin high
		@(posedge clk_sys);
		sht[20] <= 1'b0;
		wr(ADDR_ERROR_MASK, 16'h0001);
		opn[0] <= 1'b1;
		repeat (16) @(posedge clk_sys);
		#1 chk({15'h0000, fault_out_n}, 16'h0001);
		chk(mask_q, 16'h0001);
		rd(ADDR_OPEN_STAT_LO, 16'h0001);
		rd(ADDR_SHORT_STAT_HI, 16'h0000);
		$display("test fault done");
		// Feedback: soft start divides by four, then one step a frame
		wr(ADDR_SOFT_START, 16'h0002);
		target <= 9'h12C;
		frames(8);
		#1 chk({8'h00, code}, 16'h0002);
		@(posedge clk_sys);
		target <= 9'h000;
		frames(5);
		#1 chk({15'h0000, ssa}, 16'h0000);
		chk({8'h00, code}, 16'h0000);
		@(posedge clk_sys);
		target <= 9'h12C;
		frames(3);
		#1 chk({8'h00, code}, 16'h0003);
		// Gate held high and later gates alone give only one step
		@(posedge clk_sys);
		line_gate <= 8'h01;
		repeat (5) @(posedge clk_sys);
		line_gate <= 8'hFE;
		repeat (3) @(posedge clk_sys);
		line_gate <= 8'h00;
		@(posedge clk_sys);
		#1 chk({8'h00, code}, 16'h0004);
		frames(260);
		#1 chk({8'h00, code}, 16'h00FF);
		@(posedge clk_sys);
		target <= 9'h000;
		frames(1);
		#1 chk({8'h00, code}, 16'h00FE);
		$display("test feedback done");
		report_and_stop;
	end
endmodule // testbench
